// ---- rtl/brp_pkg.sv ----
/*
  Shared constants, types and decode helpers of the bit-reversal and
  program-space mapping block.
  Assumes a single core clock; no other package is needed.
*/
package brp_pkg;
  // register offsets on the plain register port
  localparam logic [7:0] REG_BITREV = 8'h00;
  localparam logic [7:0] REG_TBL_PAGE = 8'h01;
  localparam logic [7:0] REG_VIS_PAGE = 8'h02;
  localparam logic [7:0] REG_MODE = 8'h03;
  localparam logic [7:0] REG_CORE = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h05;

  // field positions
  localparam int REV_EN_BIT = 15;
  localparam int PTRSEL_LSB = 8;
  localparam int WIN_EN_BIT = 2;
  localparam int CFG_BIT = 7;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_STALL_LSB = 1;
  localparam int ST_CFG_BIT = 3;

  // values after reset
  localparam logic [15:0] BITREV_RST = 16'h0000;
  localparam logic [7:0] TBL_PAGE_RST = 8'h00;
  localparam logic [7:0] VIS_PAGE_RST = 8'h00;
  localparam logic [3:0] PTRSEL_RST = 4'hf;
  localparam logic CORE_WIN_RST = 1'b0;
  localparam logic [23:0] PC_RST = 24'h000000;

  // pointer select value that turns bit-reversal off
  localparam logic [3:0] PTR_NONE = 4'hf;
  localparam logic [23:0] PC_STEP = 24'h000002;

  // extra cycles of a window read
  localparam logic [1:0] PEN_MOVE = 2'h1;
  localparam logic [1:0] PEN_OTHER = 2'h2;
  localparam logic [1:0] PEN_RPT_EDGE = 2'h2;
  localparam logic [1:0] PEN_RPT_MID = 2'h0;

  typedef enum logic [2:0] {
    AM_IND = 3'b000,
    AM_POSTINC = 3'b001,
    AM_POSTDEC = 3'b010,
    AM_PREINC = 3'b011,
    AM_PREDEC = 3'b100,
    AM_OTHER = 3'b101
  } brp_mode_e;

  typedef enum logic [0:0] {
    PS_IDLE = 1'b0,
    PS_READ = 1'b1
  } brp_pstate_e;

  function automatic logic [15:0] rev16(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[15 - i];
    end
    return r;
  endfunction : rev16

  // reverse-carry add, result word aligned
  function automatic logic [15:0] revAdd(input logic [15:0] p, input logic [14:0] m);
    logic [15:0] s;
    s = rev16(p) + rev16({m, 1'b0});
    return rev16(s) & 16'hfffe;
  endfunction : revAdd
endpackage : brp_pkg

// ---- rtl/brp_bitrev.sv ----
/*
  X write address generation for one access: normal modes and the
  bit-reversed pre/post-increment form. Purely combinational.
  Assumes the caller decides whether bit-reversal is active.
*/
`timescale 1ns/1ps
module brp_bitrev (
  input wire logic brActive,
  input wire brp_pkg::brp_mode_e mode,
  input wire logic [15:0] ptr,
  input wire logic [15:0] offset,
  input wire logic [14:0] pivot,
  output logic [15:0] ea,
  output logic [15:0] wbData,
  output logic wbEn
);
  logic [15:0] revNext;

  // modifier scaled to bytes, reverse-carry added, lsb cleared
  assign revNext = brp_pkg::revAdd(ptr, pivot);

  always_comb begin
    ea = ptr;
    wbData = ptr;
    wbEn = 1'b0;
    case (mode)
      brp_pkg::AM_POSTINC: begin
        wbEn = 1'b1;
        ea = brActive ? (ptr & 16'hfffe) : ptr;
        wbData = brActive ? revNext : ptr + offset;
      end
      brp_pkg::AM_PREINC: begin
        wbEn = 1'b1;
        wbData = brActive ? revNext : ptr + offset;
        ea = wbData;
      end
      brp_pkg::AM_POSTDEC: begin
        wbEn = 1'b1;
        wbData = ptr - offset;
      end
      brp_pkg::AM_PREDEC: begin
        wbEn = 1'b1;
        wbData = ptr - offset;
        ea = wbData;
      end
      default: begin
        ea = ptr;
      end
    endcase
  end
endmodule : brp_bitrev

// ---- rtl/brp_prog_map.sv ----
/*
  Program address construction for table and window accesses, and
  shaping of a 24-bit program word into 16-bit read data.
  Assumes the caller has already chosen table or window use.
*/
`timescale 1ns/1ps
module brp_prog_map (
  input wire logic useTable,
  input wire logic [7:0] tblPage,
  input wire logic [7:0] visPage,
  input wire logic [15:0] ea,
  output logic [23:0] progAddr,
  input wire logic fmtHigh,
  input wire logic fmtByte,
  input wire logic fmtSel,
  input wire logic [23:0] word,
  output logic [15:0] data
);
  // window addresses never reach configuration space
  assign progAddr = useTable ? {tblPage, ea} : {1'b0, visPage, ea[14:0]};

  always_comb begin
    data = word[15:0];
    if (fmtHigh) begin
      data = {8'h00, word[23:16]};
      if (fmtByte && fmtSel) begin
        data = 16'h0000;
      end
    end else if (fmtByte) begin
      data = {8'h00, fmtSel ? word[15:8] : word[7:0]};
    end
  end
endmodule : brp_prog_map

// ---- rtl/brp_core.sv ----
/*
  Address-generation extensions of the core: bit-reversed X write
  addressing with its control registers, table access and the
  program-space window onto program memory, cycle penalties and the
  program counter step.
  Assumes the pipeline holds its request while cpuStall is high and
  that program memory answers a read with progRvalid some cycles later.
*/
// Chosen here: the strobed register port and the register offsets.
// Functional notes
// - bit-reversal only on X path writes, never on reads.
// - active needs select not 15, enable set, pre/post-increment mode.
// - control register: enable bit 15, pivot modifier bits 14..0.
// - only the modifier is reversed; pointer stays in normal order.
// - byte access or other mode gives ordinary unmodified address.
// - active: pointer plus modifier, offset ignored, address lsb zero.
// - modifier scaled to byte addresses for word data.
// - bit-reversal wins; write modulo off, read modulo still works.
// - 24-bit program space, program counter steps by two.
// - table address is page register joined to 16-bit address.
// - page bit 7 selects user or configuration memory.
// - window: address bit 15 and enable give 23-bit user address.
// - window page picks one of 256 pages; read-only, low 16 bits.
// - low table read: word bits 15..0, or selected byte.
// - high table read: bits 23..16, upper byte zero, phantom byte zero.
// - window mapping suspended while a table access runs.
// - window read outside repeat: move one extra, others two extra.
// - in repeat: edges two extra cycles, other iterations none.
`timescale 1ns/1ps
module brp_core (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  input wire logic agValid,
  input wire logic agWrite,
  input wire logic agByte,
  input wire brp_pkg::brp_mode_e agMode,
  input wire logic [3:0] agPtrIdx,
  input wire logic [15:0] agPtr,
  input wire logic [15:0] agOffset,
  input wire logic xModuloReq,
  output logic [15:0] agAddr,
  output logic agAddrValid,
  output logic agPtrWe,
  output logic [3:0] agPtrWeIdx,
  output logic [15:0] agPtrData,
  output logic agBitrevUsed,
  output logic xWrModuloEn,
  output logic xRdModuloEn,
  input wire logic dAccValid,
  input wire logic [15:0] dAccAddr,
  input wire logic dAccByte,
  input wire logic dAccIsMove,
  input wire logic rptActive,
  input wire logic rptFirst,
  input wire logic rptLast,
  input wire logic rptIntExit,
  input wire logic rptReentry,
  input wire logic tblValid,
  input wire logic tblHigh,
  input wire logic tblWrite,
  input wire logic tblByte,
  input wire logic [15:0] tblEa,
  input wire logic [15:0] tblWdata,
  output logic [23:0] progAddr,
  output logic progRd,
  output logic progWr,
  output logic [2:0] progWrMask,
  output logic [23:0] progWdata,
  output logic progConfig,
  input wire logic progRvalid,
  input wire logic [23:0] progRdata,
  output logic [15:0] rdData,
  output logic rdValid,
  output logic cpuStall,
  input wire logic pcAdvance,
  input wire logic pcLoad,
  input wire logic [22:0] pcLoadVal,
  output logic [23:0] pc
);
  logic [15:0] bitrevCtrl;
  logic [7:0] tblPage;
  logic [7:0] visPage;
  logic [3:0] ptrSel;
  logic winEn;
  logic brActive;
  logic [15:0] nextEa;
  logic [15:0] nextWb;
  logic nextWbEn;
  logic winHit;
  logic tblGo;
  logic [15:0] mapEa;
  logic [23:0] mapAddr;
  logic [15:0] fmtData;
  logic [1:0] stallCnt;
  logic [1:0] next_pen;
  logic capHigh;
  logic capByte;
  logic capSel;
  brp_pkg::brp_pstate_e pstate;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // register port, reads answered one cycle later
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bitrevCtrl <= brp_pkg::BITREV_RST;
      tblPage <= brp_pkg::TBL_PAGE_RST;
      visPage <= brp_pkg::VIS_PAGE_RST;
      ptrSel <= brp_pkg::PTRSEL_RST;
      winEn <= brp_pkg::CORE_WIN_RST;
    end else if (regWr) begin
      case (regAddr)
        brp_pkg::REG_BITREV: bitrevCtrl <= regWdata;
        brp_pkg::REG_TBL_PAGE: tblPage <= regWdata[7:0];
        brp_pkg::REG_VIS_PAGE: visPage <= regWdata[7:0];
        brp_pkg::REG_MODE: ptrSel <= regWdata[brp_pkg::PTRSEL_LSB +: 4];
        brp_pkg::REG_CORE: winEn <= regWdata[brp_pkg::WIN_EN_BIT];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      regRdata <= 16'h0000;
    end else if (regRd) begin
      case (regAddr)
        brp_pkg::REG_BITREV: regRdata <= bitrevCtrl;
        brp_pkg::REG_TBL_PAGE: regRdata <= {8'h00, tblPage};
        brp_pkg::REG_VIS_PAGE: regRdata <= {8'h00, visPage};
        brp_pkg::REG_MODE: regRdata <= {4'h0, ptrSel, 8'h00};
        brp_pkg::REG_CORE: regRdata <= {13'h0, winEn, 2'h0};
        brp_pkg::REG_STATUS:
          regRdata <= {12'h000, progConfig, stallCnt, pstate == brp_pkg::PS_READ};
        default: regRdata <= 16'h0000;
      endcase
    end else begin
      regRdata <= 16'h0000;
    end
  end

  // three enabling conditions on the selected pointer
  // byte or other mode falls back to normal
  assign brActive = agWrite && !agByte && ptrSel != brp_pkg::PTR_NONE &&
    bitrevCtrl[brp_pkg::REV_EN_BIT] && agPtrIdx == ptrSel &&
    (agMode == brp_pkg::AM_PREINC || agMode == brp_pkg::AM_POSTINC);

  // modifier reversed, pointer kept in normal order
  // pivot scaled to bytes inside the generator
  brp_bitrev u_bitrev (
    .brActive(brActive),
    .mode(agMode),
    .ptr(agPtr),
    .offset(agOffset),
    .pivot(bitrevCtrl[14:0]),
    .ea(nextEa),
    .wbData(nextWb),
    .wbEn(nextWbEn)
  );

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      agAddr <= 16'h0000;
      agAddrValid <= 1'b0;
      agPtrWe <= 1'b0;
      agPtrWeIdx <= 4'h0;
      agPtrData <= 16'h0000;
      agBitrevUsed <= 1'b0;
    end else begin
      agAddrValid <= agValid;
      agBitrevUsed <= agValid && brActive;
      // reversed update goes back into the pointer
      agPtrWe <= agValid && nextWbEn;
      if (agValid) begin
        agAddr <= nextEa;
        agPtrWeIdx <= agPtrIdx;
        agPtrData <= nextWb;
      end
    end
  end

  // bit-reversal overrides circular addressing on writes only
  assign xWrModuloEn = xModuloReq && !(agValid && brActive);
  assign xRdModuloEn = xModuloReq;

  // a table access masks the window
  assign tblGo = tblValid && pstate == brp_pkg::PS_IDLE;
  // window hit needs address bit 15 and the enable
  // window is read-only, table writes never route through it
  assign winHit = dAccValid && dAccAddr[15] && winEn && !tblValid &&
    pstate == brp_pkg::PS_IDLE;
  assign mapEa = tblGo ? tblEa : dAccAddr;

  brp_prog_map u_map (
    .useTable(tblGo),
    .tblPage(tblPage),
    .visPage(visPage),
    .ea(mapEa),
    .progAddr(mapAddr),
    .fmtHigh(capHigh),
    .fmtByte(capByte),
    .fmtSel(capSel),
    .word(progRdata),
    .data(fmtData)
  );

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      progAddr <= 24'h000000;
      progRd <= 1'b0;
      progWr <= 1'b0;
      progWrMask <= 3'h0;
      progWdata <= 24'h000000;
      progConfig <= 1'b0;
    end else begin
      progRd <= (tblGo && !tblWrite) || winHit;
      progWr <= tblGo && tblWrite;
      if (tblGo || winHit) begin
        progAddr <= mapAddr;
        progConfig <= tblGo && tblPage[brp_pkg::CFG_BIT];
      end
      if (tblGo && tblWrite) begin
        progWdata <= tblHigh ? {tblWdata[7:0], 16'h0000} :
          tblByte && tblEa[0] ? {8'h00, tblWdata[7:0], 8'h00} : {8'h00, tblWdata};
        progWrMask <= tblHigh ? 3'b100 : !tblByte ? 3'b011 : tblEa[0] ? 3'b010 : 3'b001;
      end
    end
  end

  // read shaping captured at issue, applied on return
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pstate <= brp_pkg::PS_IDLE;
      capHigh <= 1'b0;
      capByte <= 1'b0;
      capSel <= 1'b0;
    end else begin
      case (pstate)
        brp_pkg::PS_IDLE: begin
          if ((tblGo && !tblWrite) || winHit) begin
            pstate <= brp_pkg::PS_READ;
            capHigh <= tblGo && tblHigh;
            capByte <= tblGo ? tblByte : dAccByte;
            capSel <= mapEa[0];
          end
        end
        brp_pkg::PS_READ: begin
          if (progRvalid) begin
            pstate <= brp_pkg::PS_IDLE;
          end
        end
        default: pstate <= brp_pkg::PS_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdData <= 16'h0000;
      rdValid <= 1'b0;
    end else begin
      rdValid <= pstate == brp_pkg::PS_READ && progRvalid;
      if (pstate == brp_pkg::PS_READ && progRvalid) begin
        rdData <= fmtData;
      end
    end
  end

  always_comb begin
    if (!rptActive) begin
      next_pen = dAccIsMove ? brp_pkg::PEN_MOVE : brp_pkg::PEN_OTHER;
    end else if (rptFirst || rptLast || rptIntExit || rptReentry) begin
      next_pen = brp_pkg::PEN_RPT_EDGE;
    end else begin
      next_pen = brp_pkg::PEN_RPT_MID;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      stallCnt <= 2'h0;
    end else if (winHit) begin
      stallCnt <= next_pen;
    end else if (stallCnt != 2'h0) begin
      stallCnt <= stallCnt - 2'h1;
    end
  end
  assign cpuStall = stallCnt != 2'h0;

  // one program word is two address units
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pc <= brp_pkg::PC_RST;
    end else if (pcLoad) begin
      pc <= {pcLoadVal, 1'b0};
    end else if (pcAdvance) begin
      pc <= pc + brp_pkg::PC_STEP;
    end
  end

  readNoRev_a: assert property (agValid && !agWrite |=> !agBitrevUsed)
    else $error("bit-reversal used on a read");
  brevEnable_a: assert property (
    agValid && agWrite && !agByte && bitrevCtrl[brp_pkg::REV_EN_BIT] &&
    ptrSel != brp_pkg::PTR_NONE && agPtrIdx == ptrSel &&
    agMode == brp_pkg::AM_POSTINC |=> agBitrevUsed && agPtrWe)
    else $error("bit-reversal not applied when enabled");
  byteNormal_a: assert property (
    agValid && agByte && agMode == brp_pkg::AM_POSTINC |=>
    !agBitrevUsed && agPtrData == $past(agPtr) + $past(agOffset))
    else $error("byte access not given a normal address");
  lsbClear_a: assert property (agBitrevUsed |-> agAddr[0] == 1'b0)
    else $error("bit-reversed address lsb set");
  pivotScale_a: assert property (
    agValid && brActive && agPtr == 16'h0000 |=>
    agPtrData == {$past(bitrevCtrl[14:0]), 1'b0})
    else $error("modifier not scaled to bytes");
  moduloPrio_a: assert property (agValid && brActive |-> !xWrModuloEn &&
    xRdModuloEn == xModuloReq)
    else $error("modulo not overridden on writes");
  pcStep_a: assert property (pcAdvance && !pcLoad |=> pc == $past(pc) + 24'h000002)
    else $error("program counter step wrong");
  tblAddr_a: assert property (tblGo |=> progAddr == {$past(tblPage), $past(tblEa)} &&
    progConfig == progAddr[23])
    else $error("table address wrong");
  winAddr_a: assert property (winHit |=> progRd && progAddr[23] == 1'b0 &&
    progAddr[22:0] == {$past(visPage), $past(dAccAddr[14:0])})
    else $error("window address wrong");
  winSuspend_a: assert property (
    tblGo && dAccValid && dAccAddr[15] && winEn |=>
    progAddr == {$past(tblPage), $past(tblEa)})
    else $error("window taken during table access");
  stallMove_a: assert property (winHit && !rptActive && dAccIsMove |=>
    cpuStall ##1 !cpuStall)
    else $error("move penalty not one cycle");
  stallEdge_a: assert property (winHit && rptActive && rptFirst |=>
    cpuStall [*2] ##1 !cpuStall)
    else $error("repeat edge penalty not two cycles");

  brevWrite_c: cover property (agValid && brActive ##1 agPtrWe);
  winRead_c: cover property (winHit ##[1:20] rdValid);
  tblHighRead_c: cover property (tblGo && tblHigh && !tblWrite ##[1:20] rdValid);
endmodule : brp_core

// ---- test/brp_prog_mem.sv ----
/*
  Program memory stand-in: answers each read strobe with one word after
  a set latency; table writes are taken and dropped.
  Assumes one read in flight at a time, as the block guarantees.
*/
`timescale 1ns/1ps
module brp_prog_mem (
  input wire logic mclk,
  input wire logic rst,
  input wire logic progRd,
  input wire logic [3:0] lat,
  input wire logic [23:0] word,
  output logic progRvalid,
  output logic [23:0] progRdata
);
  logic [3:0] cnt;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt <= 4'h0;
      progRvalid <= 1'b0;
      progRdata <= 24'h000000;
    end else begin
      progRvalid <= (cnt == 4'h1);
      // idle lines keep moving so a stale word never looks valid
      progRdata <= (cnt == 4'h1) ? word : ~progRdata;
      if (progRd) begin
        cnt <= lat;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule : brp_prog_mem

// ---- test/brp_core_tb.sv ----
/*
  Self-checking bench of brp_core: register port, bit-reversed writes,
  table and window reads of program memory, stall count, program counter.
  Assumes brp_prog_mem on the program memory side.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_total++; \
  $display("Error t=%0t got %h want %h", $time, (a), (e)); end end
module brp_core_tb;
  logic mclk = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, agValid = 1'b0, agWrite = 1'b0;
  logic agByte = 1'b0, xModuloReq = 1'b0, dAccValid = 1'b0, dAccByte = 1'b0, dAccIsMove = 1'b0;
  logic rptActive = 1'b0, rptFirst = 1'b0, rptLast = 1'b0, rptIntExit = 1'b0, rptReentry = 1'b0;
  logic tblValid = 1'b0, tblHigh = 1'b0, tblWrite = 1'b0, tblByte = 1'b0, pcAdvance = 1'b0;
  logic pcLoad = 1'b0, progRvalid, agAddrValid, agPtrWe, agBitrevUsed, xWrModuloEn, xRdModuloEn;
  logic progRd, progWr, progConfig, rdValid, cpuStall, en = 1'b0, rdWas = 1'b0;
  logic [7:0] regAddr = 8'h00, tp = 8'h8c, pp = 8'ha5;
  logic [15:0] regWdata = 16'h0000, agPtr = 16'h0000, agOffset = 16'h0000, dAccAddr = 16'h0000;
  logic [15:0] tblEa = 16'h0000, tblWdata = 16'h0000, regRdata, agAddr, agPtrData, rdData;
  logic [15:0] lf = 16'h0033, lastWb, p;
  logic [3:0] agPtrIdx = 4'h0, agPtrWeIdx, sel = 4'hf, lat = 4'h1;
  logic [2:0] progWrMask;
  logic [14:0] pivot = 15'h0000;
  logic [22:0] pcLoadVal = 23'h000000;
  logic [23:0] progAddr, progWdata, progRdata, pc, word = 24'h000000;
  logic [23:0] expQ[$];
  logic [5:0] wcase [7] = '{6'h00, 6'h20, 6'h18, 6'h14, 6'h12, 6'h11, 6'h30};
  brp_pkg::brp_mode_e agMode = brp_pkg::AM_IND;
  int err_total = 0, total_checks = 0, cyc = 0;

  brp_core u_dut (.mclk(mclk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .agValid(agValid), .agWrite(agWrite), .agByte(agByte),
    .agMode(agMode), .agPtrIdx(agPtrIdx), .agPtr(agPtr), .agOffset(agOffset),
    .xModuloReq(xModuloReq), .agAddr(agAddr), .agAddrValid(agAddrValid), .agPtrWe(agPtrWe),
    .agPtrWeIdx(agPtrWeIdx), .agPtrData(agPtrData), .agBitrevUsed(agBitrevUsed),
    .xWrModuloEn(xWrModuloEn), .xRdModuloEn(xRdModuloEn), .dAccValid(dAccValid),
    .dAccAddr(dAccAddr), .dAccByte(dAccByte), .dAccIsMove(dAccIsMove), .rptActive(rptActive),
    .rptFirst(rptFirst), .rptLast(rptLast), .rptIntExit(rptIntExit), .rptReentry(rptReentry),
    .tblValid(tblValid), .tblHigh(tblHigh), .tblWrite(tblWrite), .tblByte(tblByte),
    .tblEa(tblEa), .tblWdata(tblWdata), .progAddr(progAddr), .progRd(progRd), .progWr(progWr),
    .progWrMask(progWrMask), .progWdata(progWdata), .progConfig(progConfig),
    .progRvalid(progRvalid), .progRdata(progRdata), .rdData(rdData), .rdValid(rdValid),
    .cpuStall(cpuStall), .pcAdvance(pcAdvance), .pcLoad(pcLoad), .pcLoadVal(pcLoadVal), .pc(pc));
  brp_prog_mem u_mem (.mclk(mclk), .rst(rst), .progRd(progRd), .lat(lat), .word(word),
    .progRvalid(progRvalid), .progRdata(progRdata));

  always #20 mclk = ~mclk;

  function automatic logic [15:0] nextRand();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf;
  endfunction : nextRand

  // carry runs from the top bit down, lsb forced clear
  function automatic logic [15:0] radd(input logic [15:0] a, input logic [15:0] m);
    logic [15:0] s;
    logic c;
    c = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      s[i] = a[i] ^ m[i] ^ c;
      c = (a[i] & m[i]) | (c & (a[i] ^ m[i]));
    end
    return s & 16'hfffe;
  endfunction : radd

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [23:0] got);
    logic [23:0] e;
    e = (expQ.size() == 0) ? ~got : expQ.pop_front();
    `CHK(got, e)
  endtask : check

  task automatic drain();
    for (int n = 0; n < 30 && expQ.size() != 0; n++) @(posedge mclk);
    if (expQ.size() != 0) begin
      err_total++;
      $display("Error t=%0t results missing", $time);
      expQ.delete();
    end
  endtask : drain

  task automatic regWrite(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : regWrite

  task automatic regRead(input logic [7:0] a, input logic [15:0] e);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    expQ.push_back({8'h00, e});
    @(posedge mclk);
    regRd <= 1'b0;
  endtask : regRead

  task automatic agReq(input logic wr, input logic by, input logic [2:0] m, input logic [3:0] idx,
      input logic [15:0] a, input logic [15:0] off);
    logic act;
    logic we;
    logic [15:0] ea;
    act = wr && !by && idx == sel && sel != 4'hf && en && (m == 3'd1 || m == 3'd3);
    lastWb = (m == 3'd1 || m == 3'd3) ? a + off : a - off;
    we = (m >= 3'd1 && m <= 3'd4);
    ea = (m == 3'd3 || m == 3'd4) ? lastWb : a;
    if (act) begin
      lastWb = radd(a, {pivot, 1'b0});
      ea = (m == 3'd1) ? (a & 16'hfffe) : lastWb;
    end
    @(posedge mclk);
    agValid <= 1'b1;
    agWrite <= wr;
    agByte <= by;
    agMode <= brp_pkg::brp_mode_e'(m);
    agPtrIdx <= idx;
    agPtr <= a;
    agOffset <= off;
    xModuloReq <= 1'b1;
    expQ.push_back({8'h00, ea});
    expQ.push_back({18'h0, idx, we, act});
    if (we) expQ.push_back({8'h00, lastWb});
    #1;
    `CHK(xWrModuloEn, !act)
    `CHK(xRdModuloEn, 1'b1)
    @(posedge mclk);
    agValid <= 1'b0;
  endtask : agReq

  task automatic progOp(input logic tbl, input logic hi, input logic wr, input logic by,
      input logic [15:0] ea, input logic [5:0] wc, input logic both);
    logic [15:0] r;
    logic [15:0] w;
    logic [7:0] b;
    logic [1:0] st;
    int cnt;
    cnt = 0;
    r = nextRand();
    // window words carry an all-ones upper byte
    word = {tbl ? r[7:0] : 8'hff, nextRand()};
    b = hi ? word[23:16] : (ea[0] ? word[15:8] : word[7:0]);
    st = wc[4] ? ((|wc[3:0]) ? 2'd2 : 2'd0) : (wc[5] ? 2'd1 : 2'd2);
    @(posedge mclk);
    tblValid <= tbl;
    tblHigh <= hi;
    tblWrite <= wr;
    tblByte <= by;
    tblEa <= ea;
    w = nextRand();
    tblWdata <= w;
    dAccValid <= !tbl || both;
    dAccAddr <= ea | 16'h8000;
    dAccByte <= by;
    {dAccIsMove, rptActive, rptFirst, rptLast, rptIntExit, rptReentry} <= wc;
    expQ.push_back(tbl ? {tp, ea} : {1'b0, pp, ea[14:0]});
    expQ.push_back({21'h0, tbl & tp[7], wr, !wr});
    if (wr) begin
      expQ.push_back(hi ? {w[7:0], 16'h0000} : {8'h00, w});
      expQ.push_back({21'h0, hi ? 3'b100 : 3'b011});
    end
    if (!wr) begin
      expQ.push_back(!by ? (hi ? {16'h0000, word[23:16]} : {8'h00, word[15:0]})
        : {16'h0000, (hi && ea[0]) ? 8'h00 : b});
    end
    @(posedge mclk);
    tblValid <= 1'b0;
    dAccValid <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      #1;
      cnt += int'(cpuStall === 1'b1);
      @(posedge mclk);
    end
    if (!tbl) `CHK(cnt, int'(st))
    drain();
  endtask : progOp

  always @(posedge mclk) begin
    rdWas = regRd;
    #1;
    if (progRd || progWr) begin
      check(progAddr);
      check({21'h0, progConfig, progWr, progRd});
      if (progWr) check(progWdata);
      if (progWr) check({21'h0, progWrMask});
    end
    if (rdValid) check({8'h00, rdData});
    if (agAddrValid) begin
      check({8'h00, agAddr});
      check({18'h0, agPtrWeIdx, agPtrWe, agBitrevUsed});
      if (agPtrWe) check({8'h00, agPtrData});
    end
    if (rdWas) check({8'h00, regRdata});
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end

  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    for (int a = 0; a < 7; a++) regRead(a[7:0], a == 3 ? 16'h0f00 : 16'h0000);
    regWrite(8'h01, 16'h008c);
    regWrite(8'h02, 16'h00a5);
    regWrite(8'h04, 16'h0004);
    regWrite(8'h00, 16'h8008);
    regWrite(8'h03, 16'h0300);
    en = 1'b1;
    pivot = 15'h0008;
    sel = 4'h3;
    // no pointer read right after the control write
    regRead(8'h00, 16'h8008);
    regRead(8'h01, 16'h008c);
    regRead(8'h02, 16'h00a5);
    drain();
    // buffer starts at an aligned address
    p = 16'h0000;
    for (int i = 0; i < 6; i++) begin
      agReq(1'b1, 1'b0, 3'd1, 4'h3, p, 16'h0002);
      p = lastWb;
    end
    for (int m = 0; m < 6; m++) begin
      for (int v = 0; v < 4; v++) begin
        agReq(v != 2, v == 1, m[2:0], v == 3 ? 4'h5 : 4'h3, nextRand(), 16'h0002);
      end
    end
    regWrite(8'h03, 16'h0f00);
    sel = 4'hf;
    agReq(1'b1, 1'b0, 3'd3, 4'hf, nextRand(), 16'h0002);
    drain();
    for (int i = 0; i < 16; i++) begin
      if (i == 8) begin
        regWrite(8'h01, 16'h000c);
        tp = 8'h0c;
      end
      lat = i[2] ? 4'h3 : 4'h1;
      progOp(1'b1, i[0], 1'b0, i[1], nextRand(), 6'h00, i[2]);
    end
    progOp(1'b1, 1'b0, 1'b1, 1'b0, nextRand(), 6'h00, 1'b0);
    progOp(1'b1, 1'b1, 1'b1, 1'b0, nextRand(), 6'h00, 1'b0);
    for (int i = 0; i < 7; i++) progOp(1'b0, 1'b0, 1'b0, i[0], nextRand(), wcase[i], 1'b0);
    // no mapping without bit 15 or without enable
    for (int i = 0; i < 2; i++) begin
      regWrite(8'h04, i ? 16'h0000 : 16'h0004);
      @(posedge mclk);
      dAccValid <= 1'b1;
      dAccAddr <= i ? 16'h8010 : 16'h1234;
      @(posedge mclk);
      dAccValid <= 1'b0;
      repeat (4) @(posedge mclk);
    end
    @(posedge mclk);
    pcLoad <= 1'b1;
    pcLoadVal <= 23'h012345;
    @(posedge mclk);
    pcLoad <= 1'b0;
    pcAdvance <= 1'b1;
    #1;
    `CHK(pc, 24'h02468a)
    @(posedge mclk);
    pcAdvance <= 1'b0;
    #1;
    `CHK(pc, 24'h02468c)
    drain();
    complete_run();
  end
endmodule : brp_core_tb
